// File: rtl/lsq_pkg.sv
// package for the led output sequencer: constants, states and pin carriers.
// assumes a single 50 mhz system clock and synchronous active-high reset.
package lsq_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned TICK_US = 1000; // one internal timer tick, in us
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
	localparam int unsigned IVAL_MS_PER_STEP = 49; // interval per setting unit, in ms
	localparam logic [3:0] IVAL_SET_MIN = 4'h1; // 49 ms
	localparam logic [3:0] IVAL_SET_MAX = 4'ha; // 490 ms
	localparam logic [3:0] IVAL_SET_RST = 4'h5;
	localparam logic [2:0] DETECT_CYCLES = 3'h4; // settle time before unused capture

	// ----------------------------------------------------------------
	// register map (ahb-lite, word aligned)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int unsigned CTRL_IVAL_LSB = 0;
	localparam int unsigned ST_STEP_LSB = 0;
	localparam int unsigned ST_STATE_LSB = 4;
	localparam int unsigned ST_CHAIN_BIT = 8;
	localparam int unsigned ST_DETECT_BIT = 9;
	localparam int unsigned ST_SEQEN_BIT = 10;
	localparam int unsigned ST_STRAP_LSB = 12;
	localparam int unsigned ST_DRIVE_LSB = 16;
	localparam int unsigned ST_UNUSED_LSB = 24;

	// ----------------------------------------------------------------
	// grouping codes, {group_strap_a, group_strap_b}
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_SINGLE = 2'h0;
	localparam logic [1:0] GRP_PAIRS = 2'h2;
	localparam logic [1:0] GRP_QUADS = 2'h1;
	localparam logic [1:0] GRP_ALL = 2'h3;

	typedef enum logic [3:0] {
		SQ_IDLE = 4'h1,
		SQ_RUN = 4'h2,
		SQ_DONE = 4'h4,
		SQ_HOLD = 4'h8
	} lsq_state_e;

	// control pins after synchronisation
	typedef struct packed {
		logic enable_n;
		logic sequencing_enable_in;
		logic group_strap_a;
		logic group_strap_b;
		logic stop;
	} lsq_pins_s;

endpackage

// File: rtl/lsq_tick_div.sv
// timer tick divider: one-cycle enable pulse every TICK_CYCLES clocks.
// assumes the system clock domain and synchronous reset.
module lsq_tick_div #(
	parameter int unsigned TICK_CYCLES = lsq_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// tick out
	output logic tick_o
);

	logic [16:0] cnt_reg;

	// ----------------------------------------------------------------
	// free running divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_reg <= 17'h0;
			tick_o <= 1'b0;
		end else if (cnt_reg >= 17'(TICK_CYCLES - 1)) begin
			cnt_reg <= 17'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 17'h1;
			tick_o <= 1'b0;
		end
	end

endmodule // lsq_tick_div

// File: rtl/lsq_sequencer.sv
// led output sequencer: turns eight channel drivers on one slot after another,
// with a daisy chain open-drain output and an ahb-lite register slave.
// assumes asynchronous pins from the lamp controller, one system clock.

// Overview of operation
// - no sequencing happens unless sequencing enable is high
// - sequencing enable low: all 8 channels on together, chain output released
// - first channel turns on as enable falls, with no interval
// - each further channel or group turns on one interval after its predecessor
// - enable rising switches every channel off and ends the sequence
// - sequencing enable falling: plain operation, tail or full stop by stop input
// - chain output is high impedance before and after a sequence event
// - single mode: grounded unused channel skipped, later slots one interval earlier
// - grouped mode: unused channel sharing a slot leaves timing unchanged
// - unused channels found at power-up, excluded from sequence and open detect
// - grouping is eight singles, four pairs, two quads or all eight
// - interval programmable 49 ms to 490 ms, linear in the setting
// - re-enable hold-off uses the same timer as the interval
module lsq_sequencer #(
	parameter int unsigned TICK_CYCLES = lsq_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// control pins, asynchronous
	input wire logic enable_n_i,
	input wire logic sequencing_enable_in_i,
	input wire logic group_strap_a_i,
	input wire logic group_strap_b_i,
	input wire logic stop_i,
	input wire logic [7:0] channel_grounded_i,
	// channel drivers
	output logic [7:0] drive_channel_o,
	output logic drive_full_o,
	output logic [7:0] open_detect_mask_o,
	// chain output, open drain
	output logic chain_out_o,
	output logic chain_out_oe_o
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// slot index of channel ch under grouping grp and unused mask
	function automatic logic [3:0] slot_of(input logic [1:0] grp, input logic [7:0] unused,
		input int ch);
		logic [3:0] n;
		n = 4'h0;
		case (grp)
			lsq_pkg::GRP_SINGLE: begin
				for (int k = 0; k < ch; k++) begin
					n = n + {3'h0, ~unused[k]};
				end
			end
			lsq_pkg::GRP_PAIRS: n = 4'(ch >> 1);
			lsq_pkg::GRP_QUADS: n = 4'(ch >> 2);
			default: n = 4'h0;
		endcase
		return n;
	endfunction

	// number of slots in one sequence
	function automatic logic [3:0] slot_count(input logic [1:0] grp, input logic [7:0] unused);
		logic [3:0] n;
		n = 4'h0;
		case (grp)
			lsq_pkg::GRP_SINGLE: begin
				for (int k = 0; k < 8; k++) begin
					n = n + {3'h0, ~unused[k]};
				end
			end
			lsq_pkg::GRP_PAIRS: n = 4'h4;
			lsq_pkg::GRP_QUADS: n = 4'h2;
			default: n = 4'h1;
		endcase
		return n;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers, three stages, filtered on stage agreement
	// ----------------------------------------------------------------
	localparam int PW = 13;
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
	assign pin_raw = {channel_grounded_i, enable_n_i, sequencing_enable_in_i,
		group_strap_a_i, group_strap_b_i, stop_i};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			filt_reg <= {8'h00, 5'h10}; // enable_n idle high
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int b = 0; b < PW; b++) begin
				if (sync2_reg[b] == sync3_reg[b]) begin
					filt_reg[b] <= sync3_reg[b];
				end
			end
		end
	end

	lsq_pkg::lsq_pins_s pins;
	logic [1:0] grp;
	assign pins = filt_reg[4:0];
	assign grp = {pins.group_strap_a, pins.group_strap_b};

	// ----------------------------------------------------------------
	// power-up detection of grounded channels
	// ----------------------------------------------------------------
	logic [2:0] det_cnt_reg;
	logic det_done_reg;
	logic [7:0] unused_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			det_cnt_reg <= 3'h0;
			det_done_reg <= 1'b0;
			unused_reg <= 8'h00;
		end else if (!det_done_reg) begin
			det_cnt_reg <= det_cnt_reg + 3'h1;
			if (det_cnt_reg == lsq_pkg::DETECT_CYCLES) begin
				det_done_reg <= 1'b1;
				unused_reg <= filt_reg[12:5];
			end
		end
	end

	assign open_detect_mask_o = det_done_reg ? ~unused_reg : 8'h00;

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	logic [3:0] ival_set_reg;
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	logic [31:0] status_word;
	lsq_pkg::lsq_state_e state_reg;
	logic [3:0] step_reg;
	logic chain_act;

	// address phase capture
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else if (hready_i) begin
			wr_pend_reg <= hsel_i && htrans_i[1] && hwrite_i;
			addr_reg <= haddr_i;
		end
	end

	// interval setting, clamped to the legal range
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ival_set_reg <= lsq_pkg::IVAL_SET_RST;
		end else if (wr_pend_reg && addr_reg == lsq_pkg::CTRL_OFS) begin
			if (hwdata_i[3:0] < lsq_pkg::IVAL_SET_MIN) begin
				ival_set_reg <= lsq_pkg::IVAL_SET_MIN;
			end else if (hwdata_i[3:0] > lsq_pkg::IVAL_SET_MAX) begin
				ival_set_reg <= lsq_pkg::IVAL_SET_MAX;
			end else begin
				ival_set_reg <= hwdata_i[3:0];
			end
		end
	end

	assign status_word = {unused_reg, drive_channel_o, 2'h0, grp, 1'b0, pins.sequencing_enable_in,
		det_done_reg, chain_act, state_reg, step_reg};

	// read data registered in the address phase
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h0;
		end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
			case (haddr_i)
				lsq_pkg::CTRL_OFS: hrdata_o <= {28'h0, ival_set_reg};
				lsq_pkg::STATUS_OFS: hrdata_o <= status_word;
				default: hrdata_o <= 32'h0;
			endcase
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ----------------------------------------------------------------
	// timer and interval counter
	// ----------------------------------------------------------------
	logic tick;
	logic [9:0] ival_ticks;
	logic [9:0] ival_cnt_reg;
	logic ival_end;

	lsq_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	assign ival_ticks = 10'(ival_set_reg * lsq_pkg::IVAL_MS_PER_STEP);
	assign ival_end = tick && (ival_cnt_reg + 10'h1 >= ival_ticks);

	// ----------------------------------------------------------------
	// sequence state machine
	// ----------------------------------------------------------------
	logic en_prev_reg;
	logic en_fall, en_rise;
	logic [3:0] slots;
	assign en_fall = en_prev_reg && !pins.enable_n;
	assign en_rise = !en_prev_reg && pins.enable_n;
	assign slots = slot_count(grp, unused_reg);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			en_prev_reg <= 1'b1;
		end else begin
			en_prev_reg <= pins.enable_n;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= lsq_pkg::SQ_IDLE;
			step_reg <= 4'h0;
			ival_cnt_reg <= 10'h0;
		end else if (!pins.sequencing_enable_in) begin
			state_reg <= lsq_pkg::SQ_IDLE;
			step_reg <= 4'h0;
			ival_cnt_reg <= 10'h0;
		end else begin
			if (tick) begin
				ival_cnt_reg <= ival_end ? 10'h0 : ival_cnt_reg + 10'h1;
			end
			case (state_reg)
				lsq_pkg::SQ_IDLE: begin
					if (en_fall && det_done_reg) begin
						state_reg <= (slots <= 4'h1) ? lsq_pkg::SQ_RUN : lsq_pkg::SQ_RUN;
						step_reg <= 4'h0;
						ival_cnt_reg <= 10'h0;
					end
				end
				lsq_pkg::SQ_RUN, lsq_pkg::SQ_DONE: begin
					if (en_rise) begin
						state_reg <= lsq_pkg::SQ_HOLD;
						ival_cnt_reg <= 10'h0;
						step_reg <= 4'h0;
					end else if (ival_end && state_reg == lsq_pkg::SQ_RUN) begin
						step_reg <= step_reg + 4'h1;
						if (step_reg + 4'h1 >= slots) begin
							state_reg <= lsq_pkg::SQ_DONE;
						end
					end
				end
				lsq_pkg::SQ_HOLD: begin
					if (ival_end) begin
						state_reg <= lsq_pkg::SQ_IDLE;
					end
				end
				default: state_reg <= lsq_pkg::SQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// channel and chain outputs
	// ----------------------------------------------------------------
	logic [7:0] on_mask;
	logic seq_active;
	assign seq_active = (state_reg == lsq_pkg::SQ_RUN) || (state_reg == lsq_pkg::SQ_DONE);
	assign chain_act = (state_reg == lsq_pkg::SQ_DONE) && !pins.enable_n;

	always_comb begin
		on_mask = 8'h00;
		for (int c = 0; c < 8; c++) begin
			on_mask[c] = !unused_reg[c] && (slot_of(grp, unused_reg, c) <= step_reg);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			drive_channel_o <= 8'h00;
			drive_full_o <= 1'b0;
			chain_out_oe_o <= 1'b0;
		end else if (pins.enable_n) begin
			drive_channel_o <= 8'h00;
			drive_full_o <= 1'b0;
			chain_out_oe_o <= 1'b0;
		end else if (!pins.sequencing_enable_in) begin
			drive_channel_o <= 8'hff;
			drive_full_o <= pins.stop;
			chain_out_oe_o <= 1'b0;
		end else begin
			drive_channel_o <= seq_active ? on_mask : 8'h00;
			drive_full_o <= 1'b1;
			chain_out_oe_o <= chain_act;
		end
	end

	assign chain_out_o = 1'b0;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_seq_start;
		pins.sequencing_enable_in && en_fall && det_done_reg && state_reg == lsq_pkg::SQ_IDLE;
	endsequence

	chk_off_when_disabled: assert property (pins.enable_n |=> drive_channel_o == 8'h00)
		else $error("channels on while enable is high");
	chk_all_on_plain: assert property (!pins.enable_n && !pins.sequencing_enable_in
		|=> drive_channel_o == 8'hff && !chain_out_oe_o)
		else $error("plain mode must drive all channels with chain released");
	chk_stop_follow: assert property (!pins.enable_n && !pins.sequencing_enable_in
		|=> drive_full_o == $past(pins.stop))
		else $error("drive level does not follow stop in plain mode");
	chk_first_slot: assert property (s_seq_start ##1 (!pins.enable_n &&
		pins.sequencing_enable_in) |=> drive_channel_o == on_mask)
		else $error("first slot not driven at start");
	chk_step_on_interval: assert property (state_reg == lsq_pkg::SQ_RUN && ival_end
		&& pins.sequencing_enable_in && !en_rise |=> step_reg == $past(step_reg) + 4'h1)
		else $error("step did not advance at interval end");
	chk_step_hold: assert property (state_reg == lsq_pkg::SQ_RUN && !ival_end
		&& pins.sequencing_enable_in && !en_rise |=> $stable(step_reg))
		else $error("step moved before interval end");
	chk_chain_idle_z: assert property (state_reg != lsq_pkg::SQ_DONE |=>
		!chain_out_oe_o)
		else $error("chain driven outside a finished sequence");
	chk_unused_off: assert property (det_done_reg && pins.sequencing_enable_in
		|=> (drive_channel_o & unused_reg) == 8'h00)
		else $error("unused channel driven in sequence");
	chk_hold_blocks: assert property (state_reg == lsq_pkg::SQ_HOLD && !ival_end
		&& pins.sequencing_enable_in |=> state_reg == lsq_pkg::SQ_HOLD)
		else $error("hold-off left early");
	chk_no_seq_off: assert property (!pins.sequencing_enable_in
		|=> state_reg == lsq_pkg::SQ_IDLE)
		else $error("sequencer active with sequencing disabled");

endmodule // lsq_sequencer

// File: testbench/lsq_far_side_model.sv
// far side of the sequencer: strap wiring, grounded unused outputs, chain wire.
// assumes the bench picks the board wiring; the chain line has a pull-up.
module lsq_far_side_model (
	// board wiring chosen by the bench
	input wire logic strap_a_float_i,
	input wire logic strap_b_float_i,
	input wire logic [7:0] unused_i,
	// chain output of the sequencer
	input wire logic chain_out_i,
	input wire logic chain_out_oe_i,
	// pins seen by the sequencer and the next driver
	output logic group_strap_a_o,
	output logic group_strap_b_o,
	output logic [7:0] channel_grounded_o,
	output logic chain_wire_o
);
	// ----------------------------------------------------------------
	// straps: only ground or floating, floating pulled high
	// ----------------------------------------------------------------
	assign group_strap_a_o = strap_a_float_i ? 1'b1 : 1'b0;
	assign group_strap_b_o = strap_b_float_i ? 1'b1 : 1'b0;
	// unused outputs tied straight to ground
	assign channel_grounded_o = unused_i;
	// ----------------------------------------------------------------
	// chain wire: pull-up wins whenever the driver lets go
	// ----------------------------------------------------------------
	assign chain_wire_o = chain_out_oe_i ? chain_out_i : 1'b1;
endmodule // lsq_far_side_model

// File: testbench/led_output_sequencer_tb.sv
// self-checking bench for the led output sequencer.
// assumes a shortened timer tick of 50 clocks and channel 3 grounded.
module led_output_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TK = 50;
	localparam int T = 49 * TK; // one interval at setting 1
	logic clk_sys_i = 1'b0, rst_i = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, drive_full, chain_o, chain_oe, chain_wire;
	logic enable_n = 1'b1, seq_en = 1'b1, stop = 1'b1, sa_cfg = 1'b0, sb_cfg = 1'b0;
	logic strap_a, strap_b;
	logic [7:0] grounded, drive, odmask;
	int num_errors = 0, checks_done = 0, cyc = 0, t0 = 0, chain_at = -1;
	int on_at [8];

	// ----------------------------------------------------------------
	// clock, cycle count, timeout and turn-on capture
	// ----------------------------------------------------------------
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			num_errors++;
			stop_test();
		end else begin
			for (int i = 0; i < 8; i++)
				if (drive[i] === 1'b1 && on_at[i] < 0) on_at[i] <= cyc;
			if (chain_oe === 1'b1 && chain_at < 0) chain_at <= cyc;
		end
	end

	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	lsq_sequencer #(.TICK_CYCLES(TK)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .enable_n_i(enable_n),
		.sequencing_enable_in_i(seq_en), .group_strap_a_i(strap_a),
		.group_strap_b_i(strap_b), .stop_i(stop), .channel_grounded_i(grounded),
		.drive_channel_o(drive), .drive_full_o(drive_full), .open_detect_mask_o(odmask),
		.chain_out_o(chain_o), .chain_out_oe_o(chain_oe));
	lsq_far_side_model far (.strap_a_float_i(sa_cfg), .strap_b_float_i(sb_cfg),
		.unused_i(8'h08), .chain_out_i(chain_o), .chain_out_oe_i(chain_oe),
		.group_strap_a_o(strap_a), .group_strap_b_o(strap_b),
		.channel_grounded_o(grounded), .chain_wire_o(chain_wire));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_near(input int got, input int exp);
		checks_done++;
		if (got < exp - 60 || got > exp + 60) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// one single word transfer, read data taken at the data phase edge
	task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge clk_sys_i);
		while (hreadyout !== 1'b1) @(posedge clk_sys_i);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys_i);
		while (hreadyout !== 1'b1) @(posedge clk_sys_i);
		rd = hrdata;
		check_val(hresp, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_regs();
		ahb_xfer(8'h00, 1'b0, 32'h0);
		check_val(rd[3:0], 4'h5);
		ahb_xfer(8'h04, 1'b1, 32'h0);
		ahb_xfer(8'h04, 1'b0, 32'h0);
		check_val({rd[31:24], rd[9]}, 9'h011);
		check_val(odmask, 8'hf7);
		ahb_xfer(8'h00, 1'b1, 32'h0);
		ahb_xfer(8'h00, 1'b0, 32'h0);
		check_val(rd[3:0], 4'h1);
		ahb_xfer(8'h00, 1'b1, 32'hf);
		ahb_xfer(8'h00, 1'b0, 32'h0);
		check_val(rd[3:0], 4'ha);
		ahb_xfer(8'h08, 1'b1, 32'h3);
		ahb_xfer(8'h08, 1'b0, 32'h0);
		check_val(rd, 32'h0);
		ahb_xfer(8'h00, 1'b1, 32'h1);
		ahb_xfer(8'h00, 1'b0, 32'h0);
		check_val(rd[3:0], 4'h1);
	endtask
	task automatic test_plain();
		seq_en <= 1'b0;
		cycles(8);
		enable_n <= 1'b0;
		cycles(8);
		check_val(drive, 8'hff);
		check_val(drive_full, 1'b1);
		cycles(T + 60);
		check_val(chain_wire, 1'b1);
		stop <= 1'b0;
		cycles(8);
		check_val(drive_full, 1'b0);
		enable_n <= 1'b1;
		cycles(8);
		check_val(drive, 8'h00);
		stop <= 1'b1;
		seq_en <= 1'b1;
		cycles(T + 100);
	endtask
	task automatic seq_case(input logic a, input logic b, input int slot_of [8], input int last);
		sa_cfg <= a;
		sb_cfg <= b;
		cycles(10);
		for (int i = 0; i < 8; i++) on_at[i] = -1;
		chain_at = -1;
		t0 = cyc;
		enable_n <= 1'b0;
		for (int n = 0; n < (last + 1) * T && chain_at < 0; n++) @(posedge clk_sys_i);
		for (int i = 0; i < 8; i++)
			if (slot_of[i] >= 0) check_near(on_at[i] - t0, 5 + slot_of[i] * T);
		check_near(chain_at - t0, 5 + last * T);
		cycles(2);
		check_val({drive_full, chain_wire}, 2'h2);
		enable_n <= 1'b1;
		cycles(8);
		check_val({drive, chain_wire}, 9'h001);
		cycles(T + 100);
	endtask
	task automatic test_holdoff();
		enable_n <= 1'b0;
		cycles(10);
		check_val(drive[0], 1'b1);
		enable_n <= 1'b1;
		cycles(20);
		enable_n <= 1'b0;
		cycles(20);
		check_val(drive, 8'h00);
		enable_n <= 1'b1;
		cycles(T + 100);
	endtask
	task automatic test_drop();
		sa_cfg <= 1'b0;
		sb_cfg <= 1'b0;
		enable_n <= 1'b0;
		cycles(T + T / 2);
		check_val(drive, 8'h03);
		stop <= 1'b0;
		seq_en <= 1'b0;
		cycles(8);
		check_val({drive, drive_full, chain_wire}, 10'h3fd);
		stop <= 1'b1;
		cycles(8);
		check_val(drive_full, 1'b1);
		enable_n <= 1'b1;
		cycles(8);
		check_val(drive, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) on_at[i] = -1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		cycles(20);
		test_regs();
		test_plain();
		seq_case(1'b0, 1'b0, '{0, 1, 2, -1, 3, 4, 5, 6}, 7);
		seq_case(1'b1, 1'b0, '{0, 0, 1, -1, 2, 2, 3, 3}, 4);
		seq_case(1'b0, 1'b1, '{0, 0, 0, -1, 1, 1, 1, 1}, 2);
		seq_case(1'b1, 1'b1, '{0, 0, 0, -1, 0, 0, 0, 0}, 1);
		test_holdoff();
		test_drop();
		stop_test();
	end
endmodule // led_output_sequencer_tb
